// >>> logic/wake_frame_and_magic_detector.sv
// Wake-up frame filters and magic packet detector with APB registers.
// Assumes rx bytes arrive on pclk in frame order, destination address first.
//
// Chosen here: the register offsets and the APB register port.
`timescale 1ns/100ps
module wake_frame_and_magic_detector
    import wake_det_pkg::*;
#(
    parameter int NUM_FILTERS = FILTER_COUNT
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire rx_beat_t rx,
    input wire logic light_sleep_state,
    output logic rx_deliver_en,
    output logic irq,
    output logic power_event_out
);

    // Register map holds at most four filters
    initial begin
        if (NUM_FILTERS < 1 || NUM_FILTERS > FILTER_COUNT) begin
            $error("NUM_FILTERS must be 1 to 4");
        end
    end

    // Bus state
    logic pready_r;
    logic pslverr_r;
    logic [31:0] prdata_r;
    logic [31:0] rdata; // Read mux output
    logic mapped; // Address hits a register
    logic setup; // APB setup cycle
    logic wr_fire; // Write takes effect
    logic rd_fire; // Read completes

    // Control and status
    logic magic_enable_r;
    logic wake_frame_enable_r;
    logic pme_sel_r; // 1 routes events to the power event pin
    logic magic_received_r;
    logic wake_frame_received_r;
    logic [EV_W-1:0] int_st_r;
    logic [EV_W-1:0] int_mask_r;
    logic [47:0] station_r;
    logic deliver_r;
    logic irq_r;
    logic pme_r;

    // Filter registers, one entry per filter
    logic [MASK_BYTES-1:0] mask_a [NUM_FILTERS];
    logic [CMD_W-1:0] cmd_a [NUM_FILTERS];
    logic [OFF_W-1:0] off_a [NUM_FILTERS];
    logic [CRC_W-1:0] exp_a [NUM_FILTERS];
    logic [NUM_FILTERS-1:0] hit; // Filter matched at end of frame

    // Frame tracking
    logic [10:0] pos_r; // Index of the current byte in the frame
    logic [47:0] dest_r;
    logic dest_own;
    logic dest_mcast;
    logic eof_ok; // Good frame ends this cycle
    logic magic_active;
    logic wake_active;

    // Magic packet scanner
    logic sync_r, sync_nxt;
    logic [2:0] ff_r, ff_nxt;
    logic [2:0] idx_r, idx_nxt;
    logic [3:0] rep_r, rep_nxt;
    logic found_r, found_nxt;
    logic magic_evt;
    logic wake_evt;
    logic [EV_W-1:0] ev;

    assign setup = psel & ~penable;
    assign wr_fire = psel & penable & pready_r & pwrite;
    assign rd_fire = psel & penable & pready_r & ~pwrite;

    // One wait-free access: ready rises for the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= RST_WORD;
        end else begin
            pready_r <= setup;
            pslverr_r <= setup & ~mapped;
            if (setup && !pwrite) begin
                prdata_r <= rdata;
            end
        end
    end

    // Read mux; unmapped reads return zero with an error
    always_comb begin
        rdata = RST_WORD;
        mapped = 1'b1;
        case (paddr)
            REG_WCS: begin
                rdata[WCS_MAGIC_EN] = magic_enable_r;
                rdata[WCS_WAKE_EN] = wake_frame_enable_r;
                rdata[WCS_PME_SEL] = pme_sel_r;
                rdata[WCS_MAGIC_RX] = magic_received_r;
                rdata[WCS_WAKE_RX] = wake_frame_received_r;
            end
            REG_IST: rdata[EV_W-1:0] = int_st_r;
            REG_IMSK: rdata[EV_W-1:0] = int_mask_r;
            REG_ADDR_LO: rdata = station_r[31:0];
            REG_ADDR_HI: rdata[15:0] = station_r[47:32];
            REG_CMD, REG_OFF, REG_CRC01, REG_CRC23: begin
                for (int i = 0; i < NUM_FILTERS; i++) begin
                    if (paddr == REG_CMD) rdata[8*i +: CMD_W] = cmd_a[i];
                    if (paddr == REG_OFF) rdata[8*i +: OFF_W] = off_a[i];
                    if (paddr == REG_CRC01 + 12'(4*(i/2))) rdata[16*(i%2) +: 16] = exp_a[i];
                end
            end
            default: begin
                mapped = 1'b0;
                for (int i = 0; i < NUM_FILTERS; i++) begin
                    if (paddr == REG_MASK0 + 12'(4*i)) begin
                        rdata[MASK_BYTES-1:0] = mask_a[i];
                        mapped = 1'b1;
                    end
                end
            end
        endcase
    end

    // Control bits; received flags are write-one-clear, hardware set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            magic_enable_r <= 1'b0;
            wake_frame_enable_r <= 1'b0;
            pme_sel_r <= 1'b0;
            magic_received_r <= 1'b0;
            wake_frame_received_r <= 1'b0;
        end else begin
            if (wr_fire && paddr == REG_WCS) begin
                magic_enable_r <= pwdata[WCS_MAGIC_EN];
                wake_frame_enable_r <= pwdata[WCS_WAKE_EN];
                pme_sel_r <= pwdata[WCS_PME_SEL];
                magic_received_r <= (magic_received_r & ~pwdata[WCS_MAGIC_RX]) | magic_evt;
                wake_frame_received_r <= (wake_frame_received_r & ~pwdata[WCS_WAKE_RX])
                    | wake_evt;
            end else begin
                magic_received_r <= magic_received_r | magic_evt;
                wake_frame_received_r <= wake_frame_received_r | wake_evt;
            end
        end
    end

    // Interrupt status clears only the bits the read returned
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_st_r <= '0;
            int_mask_r <= '0;
            station_r <= '0;
        end else begin
            if (rd_fire && paddr == REG_IST) begin
                int_st_r <= (int_st_r & ~prdata_r[EV_W-1:0]) | ev;
            end else begin
                int_st_r <= int_st_r | ev;
            end
            if (wr_fire && paddr == REG_IMSK) int_mask_r <= pwdata[EV_W-1:0];
            if (wr_fire && paddr == REG_ADDR_LO) station_r[31:0] <= pwdata;
            if (wr_fire && paddr == REG_ADDR_HI) station_r[47:32] <= pwdata[15:0];
        end
    end

    // Registered outputs; delivery stops while any detector is armed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            deliver_r <= 1'b1;
            irq_r <= 1'b0;
            pme_r <= 1'b0;
        end else begin
            deliver_r <= ~(magic_active | wake_active);
            irq_r <= ~pme_sel_r & (|(int_st_r & int_mask_r));
            pme_r <= pme_sel_r & (magic_received_r | wake_frame_received_r);
        end
    end

    // Light sleep overrides the enable bits
    assign magic_active = magic_enable_r | light_sleep_state;
    assign wake_active = wake_frame_enable_r | light_sleep_state;

    // Byte position, zero at first destination byte; saturates on long frames
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pos_r <= '0;
            dest_r <= '0;
        end else if (rx.valid) begin
            pos_r <= rx.last ? '0 : (pos_r == POS_MAX ? pos_r : pos_r + 11'd1);
            if (pos_r < 11'd6) dest_r[{pos_r[2:0], 3'b000} +: 8] <= rx.data;
        end
    end

    assign dest_own = dest_r == station_r;
    assign dest_mcast = dest_r[0]; // Broadcast is also a group address
    assign eof_ok = rx.valid & rx.last & ~rx.err;

    // Magic scan next state; any mismatch restarts the search
    always_comb begin
        sync_nxt = 1'b0;
        ff_nxt = 3'd0;
        idx_nxt = 3'd0;
        rep_nxt = 4'd0;
        found_nxt = found_r;
        if (found_r || pos_r < DA_SA_BYTES) begin
            sync_nxt = sync_r;
            ff_nxt = ff_r;
            idx_nxt = idx_r;
            rep_nxt = rep_r;
        end else if (sync_r && rx.data == station_r[{idx_r, 3'b000} +: 8]) begin
            sync_nxt = 1'b1;
            ff_nxt = ff_r;
            idx_nxt = idx_r == ADDR_LAST_BYTE ? 3'd0 : idx_r + 3'd1;
            rep_nxt = idx_r == ADDR_LAST_BYTE ? rep_r + 4'd1 : rep_r;
            found_nxt = idx_r == ADDR_LAST_BYTE && rep_r == ADDR_LAST_REP;
        end else if (rx.data == SYNC_BYTE) begin
            // Extra sync bytes are fine only before the first copy starts
            if (idx_r == 3'd0 && rep_r == 4'd0) begin
                ff_nxt = ff_r == SYNC_LEN ? ff_r : ff_r + 3'd1;
            end else begin
                ff_nxt = 3'd1;
            end
            sync_nxt = ff_nxt == SYNC_LEN;
        end
    end

    // Scanner state, cleared at every frame end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_r <= 1'b0;
            ff_r <= 3'd0;
            idx_r <= 3'd0;
            rep_r <= 4'd0;
            found_r <= 1'b0;
        end else if (rx.valid) begin
            sync_r <= rx.last ? 1'b0 : sync_nxt;
            ff_r <= rx.last ? 3'd0 : ff_nxt;
            idx_r <= rx.last ? 3'd0 : idx_nxt;
            rep_r <= rx.last ? 4'd0 : rep_nxt;
            found_r <= rx.last ? 1'b0 : found_nxt;
        end
    end

    // Unicast to another station is never a magic packet
    assign magic_evt = eof_ok & magic_active & found_nxt & (dest_own | dest_mcast);
    assign wake_evt = |hit;
    assign ev = {wake_evt, magic_evt};

    // Bytewise CRC-16 update, MSB first
    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c;
        for (int k = 7; k >= 0; k--) begin
            r = (r[15] ^ d[k]) ? ({r[14:0], 1'b0} ^ CRC_POLY) : {r[14:0], 1'b0};
        end
        return r;
    endfunction

    // One filter per entry: registers, CRC accumulator and match
    for (genvar g = 0; g < NUM_FILTERS; g++) begin : g_filt
        logic [CRC_W-1:0] crc_r;
        logic [CRC_W-1:0] crc_nxt;
        logic [10:0] rel; // Byte index inside the mask window
        logic in_win;

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                mask_a[g] <= '0;
                cmd_a[g] <= '0;
                off_a[g] <= '0;
                exp_a[g] <= '0;
            end else if (wr_fire) begin
                if (paddr == REG_MASK0 + 12'(4*g)) mask_a[g] <= pwdata[MASK_BYTES-1:0];
                if (paddr == REG_CMD) cmd_a[g] <= pwdata[8*g +: CMD_W];
                if (paddr == REG_OFF) off_a[g] <= pwdata[8*g +: OFF_W];
                if (paddr == REG_CRC01 + 12'(4*(g/2))) exp_a[g] <= pwdata[16*(g%2) +: 16];
            end
        end

        assign rel = pos_r - {3'b000, off_a[g]};
        assign in_win = pos_r >= {3'b000, off_a[g]} && rel < 11'(MASK_BYTES);
        assign crc_nxt = (in_win && mask_a[g][rel[4:0]]) ? crc_byte(crc_r, rx.data) : crc_r;

        // Accumulate in frame order, restart after each frame
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                crc_r <= CRC_INIT;
            end else if (rx.valid) begin
                crc_r <= rx.last ? CRC_INIT : crc_nxt;
            end
        end

        assign hit[g] = eof_ok & wake_active & cmd_a[g][CMD_EN]
            & (cmd_a[g][CMD_MCAST] ? dest_mcast : (dest_own & ~dest_mcast))
            & (crc_nxt == exp_a[g]);
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign rx_deliver_en = deliver_r;
    assign irq = irq_r;
    assign power_event_out = pme_r;

    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_six_ff;
        (rx.valid && !rx.last && rx.data == SYNC_BYTE && pos_r >= DA_SA_BYTES && !found_r) [*6];
    endsequence
    sequence s_magic_end;
        eof_ok && magic_active && found_nxt && (dest_own || dest_mcast);
    endsequence

    property p_sync;
        s_six_ff |=> sync_r;
    endproperty
    a_sync: assert property (p_sync) else $error("sync not seen after six FF");
    property p_magic_flag;
        s_magic_end |=> magic_received_r && int_st_r[EV_MAGIC];
    endproperty
    a_magic_flag: assert property (p_magic_flag) else $error("magic flag missed");
    property p_magic_off;
        (rx.valid && rx.last && !magic_active && !magic_received_r) |=> !magic_received_r;
    endproperty
    a_magic_off: assert property (p_magic_off) else $error("magic seen while off");
    property p_deliver_off;
        (magic_enable_r || wake_frame_enable_r) |=> !rx_deliver_en;
    endproperty
    a_deliver_off: assert property (p_deliver_off) else $error("delivery not stopped");
    property p_deliver_on;
        (!magic_enable_r && !wake_frame_enable_r && !light_sleep_state) |=> rx_deliver_en;
    endproperty
    a_deliver_on: assert property (p_deliver_on) else $error("delivery not restored");
    property p_pme;
        (pme_sel_r && magic_received_r) |=> power_event_out && !irq;
    endproperty
    a_pme: assert property (p_pme) else $error("power event wrong");
    property p_irq;
        (!pme_sel_r && (int_st_r & int_mask_r) != '0) |=> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("irq not raised");
    property p_wake;
        (eof_ok && wake_active && cmd_a[0][CMD_EN] && crc_nxt0_eq()) |=> wake_frame_received_r;
    endproperty
    a_wake: assert property (p_wake) else $error("wake flag missed");
    property p_sleep;
        light_sleep_state |=> !rx_deliver_en;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep did not arm detectors");

    // Filter 0 address class and CRC both agree
    function automatic logic crc_nxt0_eq();
        return hit[0];
    endfunction

endmodule

// >>> logic/wake_det_pkg.sv
// Constants, register map and carrier types for the wake-up detector.
// Assumes a single APB clock domain shared with the MAC receive byte stream.
package wake_det_pkg;

    // APB register byte offsets
    localparam logic [11:0] REG_WCS = 12'h000;     // Wake control and status
    localparam logic [11:0] REG_IST = 12'h004;     // Interrupt status, read clears
    localparam logic [11:0] REG_IMSK = 12'h008;    // Interrupt mask
    localparam logic [11:0] REG_ADDR_LO = 12'h00C; // Station address bytes 0..3
    localparam logic [11:0] REG_ADDR_HI = 12'h010; // Station address bytes 4..5
    localparam logic [11:0] REG_MASK0 = 12'h020;   // Filter byte masks, one word each
    localparam logic [11:0] REG_CMD = 12'h030;     // Four command fields
    localparam logic [11:0] REG_OFF = 12'h034;     // Four pattern offsets
    localparam logic [11:0] REG_CRC01 = 12'h038;   // Expected CRC, filters 0 and 1
    localparam logic [11:0] REG_CRC23 = 12'h03C;   // Expected CRC, filters 2 and 3

    // Wake control and status field positions
    localparam int WCS_MAGIC_EN = 0;
    localparam int WCS_WAKE_EN = 1;
    localparam int WCS_PME_SEL = 2;
    localparam int WCS_MAGIC_RX = 4;
    localparam int WCS_WAKE_RX = 5;

    // Interrupt status and mask bit positions
    localparam int EV_MAGIC = 0;
    localparam int EV_WAKE = 1;
    localparam int EV_W = 2;

    // Filter command field
    localparam int CMD_EN = 0;
    localparam int CMD_MCAST = 3;
    localparam int CMD_W = 4;

    // Frame and filter geometry
    localparam int FILTER_COUNT = 4;
    localparam int MASK_BYTES = 31;
    localparam int OFF_W = 8;
    localparam int CRC_W = 16;
    localparam logic [10:0] DA_SA_BYTES = 11'd12;
    localparam logic [2:0] SYNC_LEN = 3'd6;
    localparam logic [2:0] ADDR_LAST_BYTE = 3'd5;
    localparam logic [3:0] ADDR_LAST_REP = 4'd15;
    localparam logic [7:0] SYNC_BYTE = 8'hFF;
    localparam logic [10:0] POS_MAX = 11'h7FF;

    // CRC-16 generator, MSB first
    localparam logic [15:0] CRC_POLY = 16'h8005;
    localparam logic [15:0] CRC_INIT = 16'hFFFF;

    // Reset values
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    // One received byte from the MAC receive path
    typedef struct packed {
        logic valid;    // Byte present this cycle
        logic last;     // Final byte of the frame
        logic err;      // Frame had an error, with last
        logic [7:0] data;
    } rx_beat_t;

endpackage

// >>> dv/frame_source.sv
// Remote station model: plays one frame of bytes onto the receive beat.
// Assumes the bench calls play and waits for it to return before checking.
`timescale 1ns/100ps
module frame_source
    import wake_det_pkg::*;
(
    input wire logic pclk,
    output rx_beat_t rx
);
    // Line idles low on valid, data inverted so a stale byte never lingers
    initial begin
        rx = '0;
    end

    // One byte per edge; optional idle gaps model a slow sender
    task automatic play(input logic [7:0] f[$], input logic bad, input logic gaps);
        foreach (f[i]) begin
            if (gaps && i % 3 == 1) begin
                @(posedge pclk);
                rx <= '{1'b0, 1'b0, 1'b0, ~rx.data};
            end
            @(posedge pclk);
            rx <= '{1'b1, i == f.size() - 1, bad && i == f.size() - 1, f[i]};
        end
        @(posedge pclk);
        rx <= '{1'b0, 1'b0, 1'b0, ~rx.data};
    endtask
endmodule

// >>> dv/testbench.sv
// Self-checking bench for the wake detector: APB master, frame model.
// Assumes frame_source drives the receive beat and pclk is the only clock.
`timescale 1ns/100ps
module testbench;
    import wake_det_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, light, deliver, irq, pev;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic er;
    rx_beat_t rx;
    int errors = 0; // Mismatches
    int cmp_count = 0; // Comparisons made
    int seed = 32'h597837F4;
    logic [7:0] sta[6]; // Station address
    logic [7:0] foff[4]; // Filter model state
    logic [30:0] fmsk[4];
    logic [3:0] fcmd[4];
    logic [15:0] fcrc[4];
    logic [2:0] ctl; // Control bits last written
    logic [1:0] imask; // Interrupt mask last written
    logic [7:0] f[$];

    wake_frame_and_magic_detector dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rx(rx), .light_sleep_state(light),
        .rx_deliver_en(deliver), .irq(irq), .power_event_out(pev));
    frame_source src (.pclk(pclk), .rx(rx));

    // 25 MHz clock
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // Hang guard, far beyond the expected run
    initial begin
        #2000000;
        errors++;
        end_of_test();
    end

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; waits for pready with no local bound
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // No local limit: the watchdog ends a hung wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic setctl(input logic [2:0] c);
        ctl = c;
        apb(1, REG_WCS, {29'h0, c});
    endtask

    // CRC-16 over masked bytes, MSB first, in frame order
    function automatic logic [15:0] crc16(logic [7:0] q[$], int off, logic [30:0] m);
        logic [15:0] c;
        c = 16'hFFFF;
        for (int j = 0; j < 31; j++)
            if (m[j] && off + j < q.size())
                for (int b = 7; b >= 0; b--)
                    c = {c[14:0], 1'b0} ^ ((c[15] ^ q[off+j][b]) ? 16'h8005 : 16'h0000);
        return c;
    endfunction

    function automatic bit da_own(logic [7:0] q[$]);
        for (int j = 0; j < 6; j++) if (q[j] !== sta[j]) return 0;
        return 1;
    endfunction

    // Sync of six FF from byte 12 on, then sixteen station copies
    function automatic bit is_magic(logic [7:0] q[$]);
        int k;
        if (!(q[0][0] || da_own(q))) return 0;
        for (int p = 12; p + 102 <= q.size(); p++) begin
            k = 0;
            for (int j = 0; j < 6; j++) if (q[p+j] == 8'hFF) k++;
            for (int j = 0; j < 96; j++) if (q[p+6+j] == sta[j%6]) k++;
            if (k == 102) return 1;
        end
        return 0;
    endfunction

    function automatic bit is_wake(logic [7:0] q[$]);
        for (int i = 0; i < 4; i++)
            if (fcmd[i][0] && (fcmd[i][3] ? q[0][0] : da_own(q))
                && crc16(q, foff[i], fmsk[i]) == fcrc[i]) return 1;
        return 0;
    endfunction

    // da: 0 own, 1 broadcast, 2 group, 3 foreign; cp station copies after sync
    function automatic void build(input int da, input int cp);
        f = {};
        for (int j = 0; j < 6; j++)
            f.push_back(da == 0 ? sta[j] : da == 1 ? 8'hFF : da == 2 ? 8'h01 : 8'h7E);
        for (int j = 0; j < 8; j++) f.push_back(8'($random(seed)) & 8'h7F);
        if (cp > 0) for (int j = 0; j < 6; j++) f.push_back(8'hFF);
        for (int j = 0; j < cp * 6; j++) f.push_back(sta[j%6]);
        for (int j = 0; j < 60; j++) f.push_back(8'($random(seed)) & 8'h7F);
    endfunction

    // Send a frame, compare flags, status and outputs with the model, then clear
    task automatic run(input logic bad);
        bit m, w;
        // Let a fresh enable or sleep level reach the registered delivery output
        repeat (2) @(posedge pclk);
        m = !bad && (ctl[0] || light) && is_magic(f);
        w = !bad && (ctl[1] || light) && is_wake(f);
        chk(deliver, !(ctl[0] || ctl[1] || light));
        src.play(f, bad, seed[0]);
        repeat (3) @(posedge pclk);
        chk(irq, ((m && imask[0]) || (w && imask[1])) && !ctl[2]);
        chk(pev, ctl[2] && (m || w));
        apb(0, REG_WCS, 0);
        chk(rd, {26'h0, w, m, 1'b0, ctl});
        apb(0, REG_IST, 0);
        chk(rd, {30'h0, w, m});
        apb(1, REG_WCS, {26'h0, 2'b11, 1'b0, ctl});
        repeat (2) @(posedge pclk);
        chk({pev, irq}, 0);
    endtask

    task automatic prog();
        for (int i = 0; i < 4; i++) apb(1, REG_MASK0 + 12'(4 * i), {1'b0, fmsk[i]});
        apb(1, REG_CMD, {4'h0, fcmd[3], 4'h0, fcmd[2], 4'h0, fcmd[1], 4'h0, fcmd[0]});
        apb(1, REG_OFF, {foff[3], foff[2], foff[1], foff[0]});
        apb(1, REG_CRC01, {fcrc[1], fcrc[0]});
        apb(1, REG_CRC23, {fcrc[3], fcrc[2]});
        apb(0, REG_OFF, 0);
        chk(rd, {foff[3], foff[2], foff[1], foff[0]});
    endtask

    // Main sequence
    initial begin
        {psel, penable, pwrite, light} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        presetn = 1'b0;
        ctl = 3'h0;
        foreach (fcmd[k]) fcmd[k] = 4'h0;
        for (int j = 0; j < 6; j++) sta[j] = 8'($random(seed)) & 8'h7C;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        chk({29'h0, deliver, irq, pev}, 32'h4);
        foreach (sta[j]) begin
            apb(0, REG_WCS + 12'(4 * (j % 3)), 0);
            chk({31'h0, er}, 0);
            chk(rd, 0);
        end
        apb(0, 12'hFFC, 0);
        chk({31'h0, er}, 1);
        chk(rd, 0);
        $display("test reset done");
        apb(1, REG_ADDR_LO, {sta[3], sta[2], sta[1], sta[0]});
        apb(1, REG_ADDR_HI, {16'h0, sta[5], sta[4]});
        imask = 2'h3;
        apb(1, REG_IMSK, 32'h3);
        setctl(3'h1);
        for (int d = 0; d < 4; d++) begin
            build(d, 16);
            run(0);
            build(d, 15);
            run(0);
        end
        build(0, 16);
        run(1);
        imask = 2'h2;
        apb(1, REG_IMSK, 32'h2);
        run(0);
        imask = 2'h3;
        apb(1, REG_IMSK, 32'h3);
        $display("test magic done");
        setctl(3'h0);
        run(0);
        @(posedge pclk);
        light <= 1'b1;
        run(0);
        setctl(3'h4);
        run(0);
        @(posedge pclk);
        light <= 1'b0;
        $display("test sleep done");
        setctl(3'h2);
        for (int i = 0; i < 4; i++) begin
            build(i % 2 ? 2 : 0, 0);
            for (int k = 0; k < 4; k++) begin
                foff[k] = 8'd12 + (8'($random(seed)) & 8'h1F);
                fmsk[k] = 31'($random(seed));
                fcmd[k] = k == i ? {i[0], 3'b001} : 4'h0;
            end
            fcrc[i] = crc16(f, foff[i], fmsk[i]);
            prog();
            run(0);
            run(1);
            fcmd[i][3] = ~fcmd[i][3];
            prog();
            run(0);
            fcmd[i][3] = ~fcmd[i][3];
            fcrc[i] = fcrc[i] ^ 16'h0001;
            prog();
            run(0);
        end
        $display("test wake done");
        end_of_test();
    end
endmodule
